// ---- rtl/ext_pin_sync.sv ----
// Synchroniser and edge detector for the external count pin.
// Assumes the pin holds each level at least one core clock period.
module ext_pin_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pin in, edges out
    input wire logic pin,
    output logic rise,
    output logic fall
);
    // ------------------------------------------------------------
    // Two-stage sampler plus history
    // ------------------------------------------------------------
    logic meta_r;
    logic sync_r;
    logic prev_r;

    // Sampled on the rising core clock edge; meta_r feeds only sync_r
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            meta_r <= pin;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // Edges from the stable stages only
    assign rise = sync_r & ~prev_r;
    assign fall = ~sync_r & prev_r;

    one_edge_a: assert property (@(posedge clk) disable iff (rst)
        !(rise && fall)) else $error("both edges at once");

endmodule

// ---- rtl/shared_prescaler.sv ----
// Free-running 10-bit prescaler shared by both timers.
// Assumes a single core clock; each timer picks its own tap from cnt.
module shared_prescaler
    import timer0_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Prescaler state
    output logic [timer0_pkg::presc_w-1:0] cnt
);
    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    // Never stops, so both timers see one common phase
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + 10'h001;
        end
    end

    // The edge that releases reset still sees the reset value, so it is skipped
    free_run_a: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) |-> cnt == $past(cnt) + 10'h001) else $error("prescaler did not advance");

endmodule

// ---- rtl/timer0.sv ----
// 8-bit timer/counter 0 with shared prescaler tap selection.
// Assumes the core bus port: one-cycle strobes, read data the cycle after.
//
// Functional notes
// - One shared free-running 10-bit prescaler
// - Select field picks stop, clock, taps, edges
// - Taps from core clock; stop disables
// - Pin sampled on core clock before edges
// - Pin edges count even when pin outputs
// - Count register is readable, writable up-counter
// - Counting resumes cycle after a write
// - Control bits 7-3 read zero, select resets
// - Flag and enable live in shared registers
// - Overflow flag bit1, clears by vector/one
//
// Our own choice: the strobed register port.
module timer0
    import timer0_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Core interrupt handshake
    input wire logic global_irq_en,
    input wire logic vector_ack,
    output logic irq,
    // External count pin
    input wire logic ext_count_pin,
    // Shared prescaler taps for the other timer
    output logic [timer0_pkg::presc_w-1:0] presc_cnt
);
    import timer0_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [2:0] clk_sel_r;
    logic [7:0] count_r;
    logic [7:0] count_nxt;
    logic overflow_flag_t0_r;
    logic overflow_irq_en_t0_r;
    logic [7:0] rdata_r;
    logic ext_rise;
    logic ext_fall;
    logic tick;
    logic ovf;
    logic wr_cnt;
    logic wr_ctl;
    logic wr_flag;
    logic wr_mask;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    shared_prescaler u_presc (
        .clk(clk),
        .rst(rst),
        .cnt(presc_cnt)
    );

    // Pin is watched regardless of port direction, so software can count
    ext_pin_sync u_sync (
        .clk(clk),
        .rst(rst),
        .pin(ext_count_pin),
        .rise(ext_rise),
        .fall(ext_fall)
    );

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Full-address compare; the master never drives wr and rd together,
    // so a write decode never collides with a read of the same register.
    // Unmapped addresses simply decode to nothing.
    assign wr_cnt = wr && (addr == count_value_off);
    assign wr_ctl = wr && (addr == clock_control_off);
    assign wr_flag = wr && (addr == flag_reg_off);
    assign wr_mask = wr && (addr == mask_reg_off);

    // ------------------------------------------------------------
    // Count source selection
    // ------------------------------------------------------------
    // Taps come straight off the core-clock prescaler, no other clock
    // A tap fires once per period when the low prescaler bits are all ones,
    // so the first tick after a select write depends on the prescaler phase;
    // software that needs an exact first period must allow for that.
    // Edge selections use the synchronised pin, two edges behind it.
    always_comb begin
        case (clk_sel_r)
            sel_stop: tick = 1'b0;
            sel_ck: tick = 1'b1;
            sel_div8: tick = tap_hit(presc_cnt, mask_div8);
            sel_div64: tick = tap_hit(presc_cnt, mask_div64);
            sel_div256: tick = tap_hit(presc_cnt, mask_div256);
            sel_div1024: tick = tap_hit(presc_cnt, mask_div1024);
            sel_ext_fall: tick = ext_fall;
            sel_ext_rise: tick = ext_rise;
            default: tick = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    // A write takes this cycle; counting goes on from the new value next cycle
    // Trade-off: a tick that lands in the write cycle is dropped rather than
    // added to the written value, so software reads back what it wrote
    // until the next tick. Overflow is raised only on a real ff to 00 step,
    // never by a write, so a preload of 00 cannot set the flag.
    assign ovf = tick && !wr_cnt && (count_r == count_max);

    always_comb begin
        if (wr_cnt) begin
            count_nxt = wdata;
        end else if (tick) begin
            count_nxt = count_r + 8'h01;
        end else begin
            count_nxt = count_r;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_r <= count_reset;
        end else begin
            count_r <= count_nxt;
        end
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clk_sel_r <= clk_sel_reset;
        end else if (wr_ctl) begin
            clk_sel_r <= wdata[clk_sel_w-1:0];
        end
    end

    // ------------------------------------------------------------
    // Shared flag and mask bits
    // ------------------------------------------------------------
    // Set wins over a same-cycle clear, so no overflow is dropped
    // The cost is that a clear racing an overflow leaves the flag set, which
    // software sees as one more pending overflow, never as a lost one.
    // Both clear paths, vector and write-one, share the same priority.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            overflow_flag_t0_r <= 1'b0;
        end else if (ovf) begin
            overflow_flag_t0_r <= 1'b1;
        end else if (vector_ack || (wr_flag && wdata[ovf_bit])) begin
            overflow_flag_t0_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            overflow_irq_en_t0_r <= 1'b0;
        end else if (wr_mask) begin
            overflow_irq_en_t0_r <= wdata[ovf_bit];
        end
    end

    // Level request; it drops as soon as any of the three terms clears
    assign irq = global_irq_en && overflow_irq_en_t0_r && overflow_flag_t0_r;

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    // Unmapped addresses and reserved bits read as zero
    // Read data stand for one cycle only, then fall back to zero, so the
    // master must take them in the cycle right after its strobe.
    // Reads have no side effects: reading the flag does not clear it.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_r <= 8'h00;
        end else if (rd) begin
            case (addr)
                clock_control_off: rdata_r <= {5'h00, clk_sel_r};
                count_value_off: rdata_r <= count_r;
                flag_reg_off: rdata_r <= {6'h00, overflow_flag_t0_r, 1'b0};
                mask_reg_off: rdata_r <= {6'h00, overflow_irq_en_t0_r, 1'b0};
                default: rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign rdata = rdata_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    stop_holds_a: assert property (@(posedge clk) disable iff (rst)
        (clk_sel_r == sel_stop && !wr_cnt) |=> $stable(count_r))
        else $error("stopped counter moved");

    ck_counts_a: assert property (@(posedge clk) disable iff (rst)
        (clk_sel_r == sel_ck && !wr_cnt && !wr_ctl) |=> count_r == $past(count_r) + 8'h01)
        else $error("clock select did not count");

    div8_rate_a: assert property (@(posedge clk) disable iff (rst)
        (clk_sel_r == sel_div8 && !wr_cnt && presc_cnt[2:0] != 3'h7) |=> $stable(count_r))
        else $error("div8 ticked off tap");

    write_load_a: assert property (@(posedge clk) disable iff (rst)
        wr_cnt |=> count_r == $past(wdata)) else $error("count write lost");

    ovf_sets_a: assert property (@(posedge clk) disable iff (rst)
        ovf |=> overflow_flag_t0_r && count_r == 8'h00) else $error("overflow not flagged");

    wrap_only_a: assert property (@(posedge clk) disable iff (rst)
        $rose(overflow_flag_t0_r) |-> $past(count_r) == count_max)
        else $error("flag set without wrap");

    ext_rise_a: assert property (@(posedge clk) disable iff (rst)
        (clk_sel_r == sel_ext_rise && !wr_cnt && !ext_rise) |=> $stable(count_r))
        else $error("counted without rising edge");

    ctl_read_a: assert property (@(posedge clk) disable iff (rst)
        (rd && addr == clock_control_off) |=> rdata[7:3] == 5'h00)
        else $error("reserved control bits nonzero");

    irq_gate_a: assert property (@(posedge clk) disable iff (rst)
        irq |-> overflow_flag_t0_r && overflow_irq_en_t0_r && global_irq_en)
        else $error("interrupt without all enables");

    // ------------------------------------------------------------
    // Assertions: register port and flag
    // ------------------------------------------------------------
    rdata_idle_a: assert property (@(posedge clk) disable iff (rst)
        !rd
        |=> rdata == 8'h00)
        else $error("read data not idle");

    cnt_read_a: assert property (@(posedge clk) disable iff (rst)
        (rd && addr == count_value_off)
        |=> rdata == $past(count_r))
        else $error("count read wrong");

    flag_read_a: assert property (@(posedge clk) disable iff (rst)
        (rd && addr == flag_reg_off)
        |=> rdata == {6'h00, $past(overflow_flag_t0_r), 1'b0})
        else $error("flag read wrong");

    mask_read_a: assert property (@(posedge clk) disable iff (rst)
        (rd && addr == mask_reg_off)
        |=> rdata == {6'h00, $past(overflow_irq_en_t0_r), 1'b0})
        else $error("mask read wrong");

    rdata_unmapped_a: assert property (@(posedge clk) disable iff (rst)
        (rd && addr != clock_control_off && addr != count_value_off
            && addr != flag_reg_off && addr != mask_reg_off)
        |=> rdata == 8'h00)
        else $error("unmapped read not zero");

    ctl_write_a: assert property (@(posedge clk) disable iff (rst)
        wr_ctl
        |=> clk_sel_r == $past(wdata[2:0]))
        else $error("select write lost");

    mask_write_a: assert property (@(posedge clk) disable iff (rst)
        wr_mask
        |=> overflow_irq_en_t0_r == $past(wdata[ovf_bit]))
        else $error("enable write lost");

    ack_clear_a: assert property (@(posedge clk) disable iff (rst)
        (vector_ack && !ovf)
        |=> !overflow_flag_t0_r)
        else $error("vector did not clear flag");

    w1c_clear_a: assert property (@(posedge clk) disable iff (rst)
        (wr_flag && wdata[ovf_bit] && !ovf)
        |=> !overflow_flag_t0_r)
        else $error("write one did not clear flag");

    set_wins_a: assert property (@(posedge clk) disable iff (rst)
        (ovf && (vector_ack || wr_flag))
        |=> overflow_flag_t0_r)
        else $error("clear beat overflow");

    flag_hold_a: assert property (@(posedge clk) disable iff (rst)
        (!ovf && !vector_ack && !(wr_flag && wdata[ovf_bit]))
        |=> $stable(overflow_flag_t0_r))
        else $error("flag changed by itself");

    irq_on_a: assert property (@(posedge clk) disable iff (rst)
        (global_irq_en && overflow_irq_en_t0_r && overflow_flag_t0_r)
        |-> irq)
        else $error("interrupt not requested");

    // ------------------------------------------------------------
    // Assertions: count path
    // ------------------------------------------------------------
    tick_step_a: assert property (@(posedge clk) disable iff (rst)
        (tick && !wr_cnt)
        |=> count_r == $past(count_r) + 8'h01)
        else $error("tick did not advance count");

    idle_hold_a: assert property (@(posedge clk) disable iff (rst)
        (!tick && !wr_cnt)
        |=> $stable(count_r))
        else $error("count moved without tick");

    div64_rate_a: assert property (@(posedge clk) disable iff (rst)
        (clk_sel_r == sel_div64 && !wr_cnt && presc_cnt[5:0] != 6'h3f)
        |=> $stable(count_r))
        else $error("div64 ticked off tap");

    div256_rate_a: assert property (@(posedge clk) disable iff (rst)
        (clk_sel_r == sel_div256 && !wr_cnt && presc_cnt[7:0] != 8'hff)
        |=> $stable(count_r))
        else $error("div256 ticked off tap");

    div1024_rate_a: assert property (@(posedge clk) disable iff (rst)
        (clk_sel_r == sel_div1024 && !wr_cnt && presc_cnt != 10'h3ff)
        |=> $stable(count_r))
        else $error("div1024 ticked off tap");

    ext_fall_a: assert property (@(posedge clk) disable iff (rst)
        (clk_sel_r == sel_ext_fall && !wr_cnt && !ext_fall)
        |=> $stable(count_r))
        else $error("counted without falling edge");

    // Scenarios that the bench should reach
    wrap_cov: cover property (@(posedge clk) disable iff (rst) ovf);
    ext_cov: cover property (@(posedge clk) disable iff (rst)
        clk_sel_r == sel_ext_fall && ext_fall);
    irq_cov: cover property (@(posedge clk) disable iff (rst) irq ##1 !irq);
    div1024_cov: cover property (@(posedge clk) disable iff (rst)
        clk_sel_r == sel_div1024 && tick);
    w1c_cov: cover property (@(posedge clk) disable iff (rst)
        wr_flag && wdata[ovf_bit] && overflow_flag_t0_r);

endmodule

// ---- rtl/timer0_pkg.sv ----
// Constants shared by the timer0 block and its helper modules.
// Assumes an 8-bit I/O register space reached over a plain strobe port.
package timer0_pkg;

    // ------------------------------------------------------------
    // Register offsets (I/O space)
    // ------------------------------------------------------------
    localparam logic [7:0] clock_control_off = 8'h33;
    localparam logic [7:0] count_value_off = 8'h32;
    localparam logic [7:0] flag_reg_off = 8'h38;
    localparam logic [7:0] mask_reg_off = 8'h39;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int ovf_bit = 1;
    localparam int clk_sel_w = 3;
    localparam int presc_w = 10;
    localparam logic [2:0] clk_sel_reset = 3'h0;
    localparam logic [7:0] count_reset = 8'h00;
    localparam logic [7:0] count_max = 8'hff;

    // ------------------------------------------------------------
    // Clock-select encodings
    // ------------------------------------------------------------
    localparam logic [2:0] sel_stop = 3'h0;
    localparam logic [2:0] sel_ck = 3'h1;
    localparam logic [2:0] sel_div8 = 3'h2;
    localparam logic [2:0] sel_div64 = 3'h3;
    localparam logic [2:0] sel_div256 = 3'h4;
    localparam logic [2:0] sel_div1024 = 3'h5;
    localparam logic [2:0] sel_ext_fall = 3'h6;
    localparam logic [2:0] sel_ext_rise = 3'h7;

    // Prescaler tap masks: tick when all lower bits of the counter are ones
    localparam logic [9:0] mask_div8 = 10'h007;
    localparam logic [9:0] mask_div64 = 10'h03f;
    localparam logic [9:0] mask_div256 = 10'h0ff;
    localparam logic [9:0] mask_div1024 = 10'h3ff;

    // Tap test, used for every divided selection
    function automatic logic tap_hit(input logic [9:0] cnt, input logic [9:0] msk);
        tap_hit = ((cnt & msk) == msk);
    endfunction

endpackage

// ---- verification/count_pin_source.sv ----
// Behavioural source for the external count pin, standing in for the outside world.
// Assumes the bench raises go for one clock with toggles set beside it.
module count_pin_source (
    // Clock
    input wire logic clk,
    // Command from the bench
    input wire logic go,
    input wire logic [3:0] toggles,
    // Pin drive
    output logic pin
);
    timeunit 1ns;
    timeprecision 100ps;

    initial pin = 1'b0;

    // Each level is held three clocks so no edge can slip between samples
    always @(posedge clk) begin
        if (go) begin
            for (int i = 0; i < int'(toggles); i++) begin
                repeat (3) @(posedge clk);
                pin <= ~pin;
            end
        end
    end
endmodule

// ---- verification/tb.sv ----
// Self-checking bench for timer0: register port, taps, pin counting, overflow flag.
// Assumes count_pin_source drives the count pin and the bench plays the core.
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import timer0_pkg::*;

    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    typedef struct {logic [2:0] sel; logic [7:0] st; int m; logic [3:0] tg; logic [7:0] ex;} row_s;
    logic clk, rst, wr, rd, global_irq_en, vector_ack, go, irq, pin;
    logic [7:0] addr, wdata, rdata, v;
    logic [3:0] tg;
    logic [9:0] presc_cnt, cyc;
    int bad_count, tests_run;
    // Windows are whole multiples of the tap period, so the phase of the prescaler never matters
    row_s rows [8] = '{'{sel_stop, 8'h55, 8, 4'h0, 8'h55}, '{sel_ck, 8'hfe, 20, 4'h0, 8'h12},
        '{sel_div8, 8'h10, 64, 4'h0, 8'h18}, '{sel_div64, 8'h20, 128, 4'h0, 8'h22},
        '{sel_div256, 8'h30, 512, 4'h0, 8'h32}, '{sel_div1024, 8'h40, 1024, 4'h0, 8'h41},
        '{sel_ext_rise, 8'h00, 32, 4'h5, 8'h03}, '{sel_ext_fall, 8'h00, 32, 4'h5, 8'h03}};

    timer0 uut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .global_irq_en(global_irq_en), .vector_ack(vector_ack), .irq(irq),
        .ext_count_pin(pin), .presc_cnt(presc_cnt));
    count_pin_source src (.clk(clk), .go(go), .toggles(tg), .pin(pin));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Own free-running edge count since reset, to compare with the prescaler
    always @(posedge clk or posedge rst) begin
        if (rst) cyc <= 10'h000;
        else cyc <= cyc + 10'h001;
    end

    // ------------------------------------------------------------
    // Bus tasks and checks
    // ------------------------------------------------------------
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        give_verdict();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rst, wr, rd, global_irq_en, vector_ack, go} = 6'h20;
        {addr, wdata, tg} = 20'h00000;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        // Count window: ticks land on the m edges after the select write
        for (int i = 0; i < 8; i++) begin
            wr_reg(count_value_off, rows[i].st);
            wr_reg(clock_control_off, {5'h00, rows[i].sel});
            go <= (rows[i].tg != 4'h0);
            tg <= rows[i].tg;
            @(posedge clk);
            go <= 1'b0;
            repeat (rows[i].m - 3) @(posedge clk);
            wr_reg(clock_control_off, 8'h00);
            rd_reg(count_value_off, v);
            chk(v, rows[i].ex);
            $display("row %0d done", i);
        end
        @(posedge clk);
        #1;
        chk(presc_cnt, cyc);
        // Reserved control bits and an unmapped address
        wr_reg(clock_control_off, 8'hff);
        rd_reg(clock_control_off, v);
        chk(v, 8'h07);
        wr_reg(clock_control_off, 8'h00);
        rd_reg(8'h10, v);
        chk(v, 8'h00);
        // Write while running: the write cycle's tick is lost, two follow
        wr_reg(clock_control_off, {5'h00, sel_ck});
        wr_reg(count_value_off, 8'h40);
        wr_reg(clock_control_off, 8'h00);
        rd_reg(count_value_off, v);
        chk(v, 8'h42);
        $display("register tests done");
        // Flag left by the wrapping row, gated by both enables
        rd_reg(flag_reg_off, v);
        chk(v, 8'h02);
        wr_reg(mask_reg_off, 8'h02);
        rd_reg(mask_reg_off, v);
        chk(v, 8'h02);
        global_irq_en <= 1'b1;
        @(posedge clk);
        #1;
        chk(irq, 1'b1);
        @(posedge clk);
        global_irq_en <= 1'b0;
        @(posedge clk);
        #1;
        chk(irq, 1'b0);
        @(posedge clk);
        global_irq_en <= 1'b1;
        vector_ack <= 1'b1;
        @(posedge clk);
        vector_ack <= 1'b0;
        #1;
        chk(irq, 1'b0);
        rd_reg(flag_reg_off, v);
        chk(v, 8'h00);
        // Wrap again, then clear by writing one
        wr_reg(count_value_off, 8'hff);
        wr_reg(clock_control_off, {5'h00, sel_ck});
        wr_reg(clock_control_off, 8'h00);
        rd_reg(flag_reg_off, v);
        chk(v, 8'h02);
        wr_reg(flag_reg_off, 8'h02);
        rd_reg(flag_reg_off, v);
        chk(v, 8'h00);
        $display("flag tests done");
        // Reset in mid-run
        wr_reg(clock_control_off, {5'h00, sel_ck});
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        #1;
        chk(presc_cnt, 10'h000);
        chk(irq, 1'b0);
        @(posedge clk);
        rst <= 1'b0;
        rd_reg(clock_control_off, v);
        chk(v, 8'h00);
        rd_reg(count_value_off, v);
        chk(v, 8'h00);
        @(posedge clk);
        #1;
        chk(presc_cnt, cyc);
        $display("reset tests done");
        give_verdict();
    end
endmodule
